// [hdl/ascm_core.sv]
// axis synchronous mode control core with axi4-lite registers
//
// Functional notes
// - synced master homing runs on master only
// - synced slaves never home themselves
// - synced slave jog/positioning requests are ignored
// - cancelled axes run only their own requests
// - synced interpolation only from master start axis
// - cancelled interpolation runs from requested start axis
// - system stop halts every axis
// - master stop also stops its synced slaves
// - slave stop halts that slave only, plus its interpolation group if it is a member
// - stopped interpolation member stops whole group
// - limit stop halts limit-error axes and any interpolation group they are in
// - error stop halts erroring axes and any interpolation group they are in
// - cancel during master motion halts slaves
// - cancel clears gear-change and clutch flags
// - entry needs slave idle, unstopped, error free
// - unmet entry keeps axis cancelled, flag set
// - cleared request enters sync once conditions hold
// - start phase is position modulo cam cycle
// - cancel bit suspends, clearing resumes, status shows
// - sixteen axes per word, one bit each
`timescale 1ns/1ps
module ascm_core
	import ascm_pkg::*;
#(
	parameter int N = AXES_DEF
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [N-1:0]      axis_busy,
	input  wire logic [N-1:0]      axis_limit_err,
	input  wire logic [N-1:0]      axis_error,
	input  wire logic [N-1:0]      gear_change_set,
	input  wire logic [N-1:0]      clutch_on_set,
	input  wire logic [31:0]       master_position,
	output logic [N-1:0]           home_start,
	output logic [N-1:0]           manual_jog_motion_start,
	output logic [N-1:0]           pos_start,
	output logic [N-1:0]           interp_start,
	output logic [N-1:0]           axis_stop,
	output logic [N-1:0]           sync_cancel_active_word,
	output logic [31:0]            cam_phase
);
	localparam int IW = $clog2(N);  // master index width

	// whole block state
	typedef struct packed {
		logic              awready;     // write address slot free
		logic              aw_got;      // write address held
		logic [ADDR_W-1:0] aw_addr;
		logic              wready;      // write data slot free
		logic              w_got;       // write data held
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic [N-1:0]      cancel_req;  // sync_cancel_request_word
		logic [N-1:0]      slave_mask;
		logic [IW-1:0]     master_idx;
		logic [N-1:0]      group_mask;
		logic [31:0]       cam_cycle;
		logic [31:0]       cam_phase;
		logic              cam_start;   // launch remainder unit
		logic [N-1:0]      sync;        // per-axis synchronised
		logic [N-1:0]      gear_flag;   // ratio change in progress
		logic [N-1:0]      clutch_flag; // clutch engaged
		logic [N-1:0]      stop_pend;   // stop issued, axis moving
		logic [N-1:0]      home_req;    // one-cycle request pulses
		logic [N-1:0]      jog_req;
		logic [N-1:0]      pos_req;
		logic [N-1:0]      interp_req;
		logic [N-1:0]      stop_req;
		logic              sys_stop;
		logic [N-1:0]      home_o;      // registered routed outputs
		logic [N-1:0]      jog_o;
		logic [N-1:0]      pos_o;
		logic [N-1:0]      interp_o;
		logic [N-1:0]      stop_o;
		logic [N-1:0]      cact;        // cancel active, inverse of sync
	} ascm_state_type;
	ascm_state_type st_reg;
	ascm_state_type st_next;

	logic [N-1:0] mbit;         // master one-hot
	logic [N-1:0] synced;       // synchronised slaves
	logic [N-1:0] entry_ok;     // sync entry conditions per axis
	logic [N-1:0] cancel_halt;  // slaves cut off by a cancel
	logic [N-1:0] home_go;
	logic [N-1:0] jog_go;
	logic [N-1:0] pos_go;
	logic [N-1:0] interp_go;
	logic [N-1:0] stop_go;
	logic         cam_busy;
	logic         cam_done;
	logic [31:0]  cam_rem;
	logic [31:0]  wv;           // merged write value
	logic [32:0]  rd_hit;       // {mapped, data} of a read
	logic [32:0]  wr_hit;       // {mapped, old data} at write address

	// one-hot of an axis number
	function automatic logic [N-1:0] axis_bit(input logic [IW-1:0] idx);
		logic [N-1:0] b;
		b = '0;
		b[idx] = 1'b1;
		return b;
	endfunction

	// widen an axis word into a bus word
	function automatic logic [31:0] wide(input logic [N-1:0] v);
		return {{(32-N){1'b0}}, v};
	endfunction

	// register read mux, top bit flags a mapped address
	function automatic logic [32:0] regread(
		input ascm_state_type s,
		input logic [ADDR_W-1:0] a
	);
		if (a == OFS_CANCEL_REQ)
			return {1'b1, wide(s.cancel_req)};
		else if (a == OFS_CANCEL_ACT)
			return {1'b1, wide(~s.sync)};
		else if (a == OFS_SLAVE_MASK)
			return {1'b1, wide(s.slave_mask)};
		else if (a == OFS_MASTER_IDX)
			return {1'b1, {(32-IW){1'b0}}, s.master_idx};
		else if (a == OFS_GROUP_MASK)
			return {1'b1, wide(s.group_mask)};
		else if (a == OFS_CAM_CYCLE)
			return {1'b1, s.cam_cycle};
		else if (a == OFS_CAM_PHASE)
			return {1'b1, s.cam_phase};
		else if (a == OFS_GEAR_FLAG)
			return {1'b1, wide(s.gear_flag)};
		else if (a == OFS_CLUTCH_FLG)
			return {1'b1, wide(s.clutch_flag)};
		else if (a >= OFS_HOME_REQ && a <= OFS_SYS_STOP && a[1:0] == 2'h0)
			return {1'b1, 32'h0000_0000};  // pulse registers read zero
		else
			return {1'b0, 32'h0000_0000};
	endfunction

	// byte-lane merge of write data into the old value
	function automatic logic [31:0] wm32(
		input logic [31:0] old,
		input logic [31:0] d,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	// per-axis derived vectors
	assign mbit = axis_bit(st_reg.master_idx);
	assign synced = st_reg.slave_mask & st_reg.sync;
	assign entry_ok = ~axis_busy & ~st_reg.stop_pend & ~st_reg.stop_req
		& ~axis_error & ~axis_limit_err & ~{N{st_reg.sys_stop}};
	assign cancel_halt = synced & st_reg.cancel_req
		& {N{|(mbit & axis_busy)}};
	assign rd_hit = regread(st_reg, araddr);
	assign wr_hit = regread(st_reg, st_reg.aw_addr);
	assign wv = wm32(wr_hit[31:0], st_reg.wdata, st_reg.wstrb);

	// request and stop routing
	ascm_route #(
		.N (N)
	) u_route (
		.synced      (synced),
		.mbit        (mbit),
		.home_req    (st_reg.home_req),
		.jog_req     (st_reg.jog_req),
		.pos_req     (st_reg.pos_req),
		.interp_req  (st_reg.interp_req),
		.stop_req    (st_reg.stop_req),
		.sys_stop    (st_reg.sys_stop),
		.lim_err     (axis_limit_err),
		.err         (axis_error),
		.group_mask  (st_reg.group_mask),
		.cancel_halt (cancel_halt),
		.home_go     (home_go),
		.jog_go      (jog_go),
		.pos_go      (pos_go),
		.interp_go   (interp_go),
		.stop_go     (stop_go)
	);

	// cam phase remainder at sync start
	ascm_cam_phase u_cam (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.start     (st_reg.cam_start),
		.dividend  (master_position),
		.divisor   (st_reg.cam_cycle),
		.busy      (cam_busy),
		.done      (cam_done),
		.remainder (cam_rem)
	);

	// next state: bus slave, sync control, routed outputs
	always_comb
	begin
		st_next = st_reg;
		st_next.home_req = '0;
		st_next.jog_req = '0;
		st_next.pos_req = '0;
		st_next.interp_req = '0;
		st_next.stop_req = '0;
		st_next.sys_stop = 1'b0;
		st_next.cam_start = 1'b0;
		// address and data channels taken in either order
		if (awvalid && st_reg.awready)
		begin
			st_next.awready = 1'b0;
			st_next.aw_got = 1'b1;
			st_next.aw_addr = awaddr;
		end
		if (wvalid && st_reg.wready)
		begin
			st_next.wready = 1'b0;
			st_next.w_got = 1'b1;
			st_next.wdata = wdata;
			st_next.wstrb = wstrb;
		end
		// both halves present: perform the write
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid)
		begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = RESP_OKAY;
			if (st_reg.aw_addr == OFS_CANCEL_REQ)
				st_next.cancel_req = wv[N-1:0];
			else if (st_reg.aw_addr == OFS_SLAVE_MASK)
				st_next.slave_mask = wv[N-1:0] & ~mbit;
			else if (st_reg.aw_addr == OFS_MASTER_IDX)
			begin
				st_next.master_idx = wv[IW-1:0];
				st_next.slave_mask = st_reg.slave_mask
					& ~axis_bit(wv[IW-1:0]);
			end
			else if (st_reg.aw_addr == OFS_GROUP_MASK)
				st_next.group_mask = wv[N-1:0];
			else if (st_reg.aw_addr == OFS_CAM_CYCLE)
				st_next.cam_cycle = wv;
			else if (st_reg.aw_addr == OFS_HOME_REQ)
				st_next.home_req = wv[N-1:0];
			else if (st_reg.aw_addr == OFS_JOG_REQ)
				st_next.jog_req = wv[N-1:0];
			else if (st_reg.aw_addr == OFS_POS_REQ)
				st_next.pos_req = wv[N-1:0];
			else if (st_reg.aw_addr == OFS_INTERP_REQ)
				st_next.interp_req = wv[N-1:0];
			else if (st_reg.aw_addr == OFS_STOP_REQ)
				st_next.stop_req = wv[N-1:0];
			else if (st_reg.aw_addr == OFS_SYS_STOP)
				st_next.sys_stop = wv[0];
			else if (!wr_hit[32])
				st_next.bresp = RESP_SLVERR;  // unmapped
		end
		// response taken: reopen both write slots
		if (st_reg.bvalid && bready)
		begin
			st_next.bvalid = 1'b0;
			st_next.awready = 1'b1;
			st_next.wready = 1'b1;
		end
		// read: answer one cycle after the address
		if (arvalid && st_reg.arready)
		begin
			st_next.arready = 1'b0;
			st_next.rvalid = 1'b1;
			st_next.rdata = rd_hit[31:0];
			st_next.rresp = rd_hit[32] ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_reg.rvalid && rready)
		begin
			st_next.rvalid = 1'b0;
			st_next.arready = 1'b1;
		end
		// slave flags set only while synchronised
		st_next.gear_flag = st_reg.gear_flag | (gear_change_set & synced);
		st_next.clutch_flag = st_reg.clutch_flag | (clutch_on_set & synced);
		// per-axis sync state machine
		for (int i = 0; i < N; i++)
		begin
			if (!st_reg.slave_mask[i])
				st_next.sync[i] = 1'b0;
			else if (st_reg.cancel_req[i])
			begin
				st_next.sync[i] = 1'b0;
				st_next.gear_flag[i] = 1'b0;
				st_next.clutch_flag[i] = 1'b0;
			end
			else if (!st_reg.sync[i] && entry_ok[i])
			begin
				st_next.sync[i] = 1'b1;
				st_next.cam_start = !cam_busy;
			end
			// unmet entry: sync stays low, status stays set
		end
		if (cam_done)
			st_next.cam_phase = cam_rem;
		// routed outputs and stop bookkeeping
		st_next.home_o = home_go;
		st_next.jog_o = jog_go;
		st_next.pos_o = pos_go;
		st_next.interp_o = interp_go;
		st_next.stop_o = stop_go;
		st_next.stop_pend = (st_reg.stop_pend & axis_busy) | stop_go;
		st_next.cact = ~st_next.sync;
	end

	// state register with reset values
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg <= '0;
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
			st_reg.arready <= 1'b1;
			st_reg.cancel_req <= CANCEL_RST[N-1:0];
			st_reg.cam_cycle <= CAM_CYCLE_RST;
			st_reg.cact <= '1;
		end
		else
			st_reg <= st_next;
	end

	// ports straight from the state register
	assign awready = st_reg.awready;
	assign wready = st_reg.wready;
	assign bvalid = st_reg.bvalid;
	assign bresp = st_reg.bresp;
	assign arready = st_reg.arready;
	assign rvalid = st_reg.rvalid;
	assign rresp = st_reg.rresp;
	assign rdata = st_reg.rdata;
	assign home_start = st_reg.home_o;
	assign manual_jog_motion_start = st_reg.jog_o;
	assign pos_start = st_reg.pos_o;
	assign interp_start = st_reg.interp_o;
	assign axis_stop = st_reg.stop_o;
	assign sync_cancel_active_word = st_reg.cact;
	assign cam_phase = st_reg.cam_phase;

	// checks on routing and sync control
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_home_master_only: assert property (
		|(st_reg.home_req & mbit) |=> |(home_start & $past(mbit)))
		else $error("master home request not forwarded");
	a_home_slave_block: assert property (
		##1 (home_start & $past(synced & st_reg.home_req)) == '0)
		else $error("synced slave started homing");
	a_jog_slave_block: assert property (
		##1 ((manual_jog_motion_start | pos_start)
			& $past(synced & (st_reg.jog_req | st_reg.pos_req))) == '0)
		else $error("synced slave jogged or positioned");
	a_jog_cancel_exact: assert property (
		##1 manual_jog_motion_start == $past(st_reg.jog_req & ~synced))
		else $error("jog routing wrong");
	a_interp_exact: assert property (
		##1 interp_start == $past(st_reg.interp_req & ~synced))
		else $error("interpolation routing wrong");
	a_sys_stop_all: assert property (
		st_reg.sys_stop |=> &axis_stop)
		else $error("system stop missed an axis");
	a_master_stop_spread: assert property (
		|(st_reg.stop_req & mbit) |=>
			(axis_stop & $past(synced)) == $past(synced))
		else $error("master stop did not reach slaves");
	a_limit_stop_hit: assert property (
		##1 (axis_stop & $past(axis_limit_err)) == $past(axis_limit_err))
		else $error("limit error axis not stopped");
	a_cancel_clears: assert property (
		|(synced & st_reg.cancel_req) |=>
			((st_reg.clutch_flag | st_reg.gear_flag)
			& $past(synced & st_reg.cancel_req)) == '0)
		else $error("sync flags survived a cancel");
	a_entry_guard: assert property (
		##1 ((st_reg.sync & ~$past(st_reg.sync))
			& ~$past(entry_ok)) == '0)
		else $error("sync entered with conditions unmet");
	a_phase_time: assert property (
		st_reg.cam_start |-> ##[1:40] cam_done)
		else $error("cam phase not ready in time");

	c_sync_entry: cover property (|(st_reg.sync & ~$past(st_reg.sync)));
	c_cancel_halt: cover property (|cancel_halt);
	c_group_stop: cover property (|(axis_stop & st_reg.group_mask));
	c_phase_done: cover property (cam_done);
endmodule

// [include/ascm_pkg.sv]
// constants shared by the axis synchronous mode control block
package ascm_pkg;
	localparam int          ADDR_W         = 6;       // axi byte address bits
	localparam int          AXES_DEF       = 16;      // axes per request word
	localparam logic [5:0]  OFS_CANCEL_REQ = 6'h00;   // sync cancel request
	localparam logic [5:0]  OFS_CANCEL_ACT = 6'h04;   // sync cancel active
	localparam logic [5:0]  OFS_SLAVE_MASK = 6'h08;   // axes used as slaves
	localparam logic [5:0]  OFS_MASTER_IDX = 6'h0c;   // master axis number
	localparam logic [5:0]  OFS_GROUP_MASK = 6'h10;   // interpolation group
	localparam logic [5:0]  OFS_CAM_CYCLE  = 6'h14;   // master cam cycle
	localparam logic [5:0]  OFS_CAM_PHASE  = 6'h18;   // phase at sync start
	localparam logic [5:0]  OFS_HOME_REQ   = 6'h1c;   // home return pulses
	localparam logic [5:0]  OFS_JOG_REQ    = 6'h20;   // jog pulses
	localparam logic [5:0]  OFS_POS_REQ    = 6'h24;   // positioning pulses
	localparam logic [5:0]  OFS_INTERP_REQ = 6'h28;   // interp start pulses
	localparam logic [5:0]  OFS_STOP_REQ   = 6'h2c;   // emerg/decel stops
	localparam logic [5:0]  OFS_SYS_STOP   = 6'h30;   // system stop, bit 0
	localparam logic [5:0]  OFS_GEAR_FLAG  = 6'h34;   // ratio change flags
	localparam logic [5:0]  OFS_CLUTCH_FLG = 6'h38;   // clutch engaged flags
	localparam logic [31:0] CANCEL_RST     = 32'hffff_ffff; // all cancelled
	localparam logic [31:0] CAM_CYCLE_RST  = 32'h0001_0000; // plain default
	localparam logic [1:0]  RESP_OKAY      = 2'h0;    // axi okay
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;    // axi slave error
	localparam logic [5:0]  PHASE_STEPS    = 6'h20;   // remainder iterations
endpackage

// [hdl/ascm_cam_phase.sv]
// serial remainder unit for the cam phase at sync start
`timescale 1ns/1ps
module ascm_cam_phase
	import ascm_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        start,
	input  wire logic [31:0] dividend,
	input  wire logic [31:0] divisor,
	output logic             busy,
	output logic             done,
	output logic [31:0]      remainder
);
	// whole unit state
	typedef struct packed {
		logic        busy;  // iterating
		logic        done;  // one-cycle result strobe
		logic [5:0]  cnt;   // steps left
		logic [31:0] quo;   // dividend bits shifting out
		logic [31:0] rem;   // partial remainder
		logic [31:0] div;   // latched divisor
	} ascm_cp_type;
	ascm_cp_type cp_reg;
	ascm_cp_type cp_next;
	logic [32:0] trial;  // shifted remainder before compare

	// one restoring step per clock
	always_comb
	begin
		cp_next = cp_reg;
		cp_next.done = 1'b0;
		trial = {cp_reg.rem, cp_reg.quo[31]};
		if (start && !cp_reg.busy)
		begin
			cp_next.busy = 1'b1;
			cp_next.cnt = PHASE_STEPS;
			cp_next.quo = dividend;
			cp_next.rem = '0;
			cp_next.div = divisor;
		end
		else if (cp_reg.busy)
		begin
			cp_next.quo = {cp_reg.quo[30:0], 1'b0};
			// zero cycle: phase is the plain position
			if (cp_reg.div == '0 || trial < {1'b0, cp_reg.div})
				cp_next.rem = trial[31:0];
			else
				cp_next.rem = 32'(trial - {1'b0, cp_reg.div});
			cp_next.cnt = 6'(cp_reg.cnt - 6'h01);
			if (cp_reg.cnt == 6'h01)
			begin
				cp_next.busy = 1'b0;
				cp_next.done = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cp_reg <= '0;
		else
			cp_reg <= cp_next;
	end

	assign busy = cp_reg.busy;
	assign done = cp_reg.done;
	assign remainder = cp_reg.rem;
endmodule

// [hdl/ascm_route.sv]
// routing of motion requests and stops by per-axis sync state
`timescale 1ns/1ps
module ascm_route #(
	parameter int N = 16
) (
	input  wire logic [N-1:0] synced,      // slaves now synchronised
	input  wire logic [N-1:0] mbit,        // master axis one-hot
	input  wire logic [N-1:0] home_req,
	input  wire logic [N-1:0] jog_req,
	input  wire logic [N-1:0] pos_req,
	input  wire logic [N-1:0] interp_req,  // requested start axis
	input  wire logic [N-1:0] stop_req,    // emergency or decelerated
	input  wire logic         sys_stop,
	input  wire logic [N-1:0] lim_err,
	input  wire logic [N-1:0] err,
	input  wire logic [N-1:0] group_mask,
	input  wire logic [N-1:0] cancel_halt,
	output logic [N-1:0]      home_go,
	output logic [N-1:0]      jog_go,
	output logic [N-1:0]      pos_go,
	output logic [N-1:0]      interp_go,
	output logic [N-1:0]      stop_go
);
	logic [N-1:0] stop_pre;  // stops before group spread

	// starts: a synced slave never moves on its own
	always_comb
	begin
		home_go = home_req & ~synced;
		jog_go = jog_req & ~synced;
		pos_go = pos_req & ~synced;
		interp_go = interp_req & ~synced;
		// master stop drags its synced slaves along
		stop_pre = stop_req;
		if (|(stop_req & mbit))
			stop_pre = stop_pre | synced;
		stop_pre = stop_pre | lim_err;
		stop_pre = stop_pre | err;
		stop_pre = stop_pre | cancel_halt;
		// any stopped member halts the whole group
		if (|(stop_pre & group_mask))
			stop_pre = stop_pre | group_mask;
		stop_go = sys_stop ? '1 : stop_pre;
	end
endmodule

// [bench/ascm_axis_model.sv]
// axis motion generator stand-in for the sync control bench
`timescale 1ns/1ps
module ascm_axis_model #(
	parameter int N = 16
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [N-1:0] starts,  // any start pulse per axis
	input  wire logic [N-1:0] stops,   // stop command per axis
	output logic [N-1:0]      busy     // axis moving
);
	// an axis moves from its start until a stop lands
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			busy <= '0;
		else
			busy <= (busy | starts) & ~stops;
	end
endmodule

// [bench/test_axis_sync_mode_control.sv]
// self-checking bench for the axis sync mode control core
`timescale 1ns/1ps
module test_axis_sync_mode_control;
	import ascm_pkg::*;
	localparam int N = 16;
	logic         aclk = 0, aresetn = 0;
	logic [5:0]   awaddr = '0, araddr = '0;
	logic         awvalid = 0, wvalid = 0, bready = 0;
	logic         arvalid = 0, rready = 0;
	logic [31:0]  wdata = '0, mpos = '0, rdata, cam_phase;
	logic         awready, wready, bvalid, arready, rvalid;
	logic [1:0]   bresp, rresp;
	logic [N-1:0] busy, lim = '0, err = '0, gear = '0, clut = '0;
	logic [N-1:0] home, manual_jog_motion, pos, itp, stp, cact;
	logic [63:0]  notes[$];    // expected {home, jog, pos, interp}
	int           num_errors = 0, tests_run = 0;
	always #2.5 aclk = ~aclk;
	ascm_core #(.N(N)) ascm_core_inst (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .axis_busy(busy), .axis_limit_err(lim),
		.axis_error(err), .gear_change_set(gear), .clutch_on_set(clut),
		.master_position(mpos), .home_start(home),
		.manual_jog_motion_start(manual_jog_motion), .pos_start(pos),
		.interp_start(itp), .axis_stop(stp),
		.sync_cancel_active_word(cact), .cam_phase(cam_phase));
	ascm_axis_model #(.N(N)) ascm_axis_model_inst (.aclk(aclk),
		.aresetn(aresetn), .starts(home | manual_jog_motion | pos | itp), .stops(stp),
		.busy(busy));
	task automatic bad(input string what, input logic [63:0] e, g);
		num_errors++;
		$display("BAD %s expected %h seen %h", what, e, g);
	endtask
	task automatic chk(input string what, input logic [63:0] e, g);
		tests_run++;
		if (g !== e)
			bad(what, e, g);
	endtask
	// full axi write, both halves offered together
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid && n < 40);
		bready <= 1'b0;
		if (!bvalid)
		begin
			bad("bvalid timeout", 64'h1, 64'h0);
			close_out();
		end
		else
			chk("bresp", RESP_OKAY, bresp);
	endtask
	// axi read compared with expected data and response
	task automatic rd(input logic [5:0] a, input logic [31:0] e,
		input logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid && n < 40);
		rready <= 1'b0;
		if (!rvalid)
		begin
			bad("rvalid timeout", 64'h1, 64'h0);
			close_out();
		end
		else
		begin
			chk("rdata", e, rdata);
			chk("rresp", r, rresp);
		end
	endtask
	// request pulse of mode k: 0 home, 1 jog, 2 pos, 3 interp
	task automatic go(input int k, input logic [15:0] d, v);
		notes.push_back({48'h0, v} << (16 * (3 - k)));
		wr(OFS_HOME_REQ + 6'(4 * k), {16'h0, d});
	endtask
	// stop command seen one edge after the write answer
	task automatic stopchk(input logic [5:0] a, input logic [31:0] d,
		input logic [15:0] e);
		wr(a, d);
		#1;
		chk("stop", e, stp);
	endtask
	task automatic waitstop(input logic [15:0] e);
		int n;
		n = 0;
		do
		begin
			@(posedge aclk);
			#1;
			n++;
		end
		while (stp === '0 && n < 10);
		chk("stop", e, stp);
		repeat (3) @(posedge aclk);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// pops the oldest note whenever any start pulse shows
	always @(posedge aclk)
	begin
		if (aresetn && (home | manual_jog_motion | pos | itp) !== '0)
		begin
			if (notes.size() == 0)
				bad("spare start", '0, {home, manual_jog_motion, pos, itp});
			else
				chk("starts", notes.pop_front(), {home, manual_jog_motion, pos, itp});
		end
	end
	// main sequence
	initial
	begin
		logic [31:0] p;
		logic [31:0] c;
		void'($urandom(16));
		c = $urandom_range(200, 1);
		p = $urandom_range(65535, 0);
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		mpos <= p;
		rd(OFS_CANCEL_ACT, 32'h0000_ffff, RESP_OKAY);
		rd(6'h3c, 32'h0, RESP_SLVERR);
		wr(OFS_SLAVE_MASK, 32'h6);
		wr(OFS_MASTER_IDX, 32'h0);
		wr(OFS_GROUP_MASK, 32'h0);
		wr(OFS_CAM_CYCLE, c);
		err <= 16'h2;
		wr(OFS_CANCEL_REQ, 32'h0);
		rd(OFS_CANCEL_ACT, 32'h0000_fffb, RESP_OKAY);
		err <= '0;
		repeat (40) @(posedge aclk);
		rd(OFS_CANCEL_ACT, 32'h0000_fff9, RESP_OKAY);
		chk("cancel_active", 16'hfff9, cact);
		rd(OFS_CAM_PHASE, p % c, RESP_OKAY);
		chk("cam_phase", p % c, cam_phase);
		for (int k = 0; k < 4; k++)
			go(k, 16'h3, 16'h1);
		stopchk(OFS_STOP_REQ, 32'h2, 16'h2);
		stopchk(OFS_STOP_REQ, 32'h1, 16'h7);
		stopchk(OFS_SYS_STOP, 32'h1, 16'hffff);
		lim <= 16'h10;
		waitstop(16'h10);
		lim <= '0;
		err <= 16'h20;
		waitstop(16'h20);
		err <= '0;
		go(1, 16'h1, 16'h1);
		gear <= 16'h6;
		clut <= 16'h6;
		@(posedge aclk);
		gear <= '0;
		clut <= '0;
		rd(OFS_GEAR_FLAG, 32'h6, RESP_OKAY);
		stopchk(OFS_CANCEL_REQ, 32'h6, 16'h6);
		rd(OFS_GEAR_FLAG, 32'h0, RESP_OKAY);
		rd(OFS_CLUTCH_FLG, 32'h0, RESP_OKAY);
		rd(OFS_CANCEL_ACT, 32'h0000_ffff, RESP_OKAY);
		chk("cancel_active", 16'hffff, cact);
		go(1, 16'h2, 16'h2);
		wr(OFS_GROUP_MASK, 32'h18);
		go(3, 16'h8, 16'h8);
		stopchk(OFS_STOP_REQ, 32'h8, 16'h18);
		repeat (4) @(posedge aclk);
		if (notes.size() != 0)
			bad("notes left", 64'h0, notes.size());
		close_out();
	end
endmodule
